// File: hall_switch_temp_ui_config_bench.sv
// Self-checking bench for the switch and temperature UI register bank
`timescale 1ns/10ps
module hall_switch_temp_ui_config_bench;
    logic       clock_in = 1'b0;
    logic       reset_in = 1'b1;
    logic       fdir     = 1'b0;
    logic       req      = 1'b0;
    logic       prox     = 1'b0;
    logic [7:0] addr, wdata, rdata, pthr, phys;
    logic       wr, rd, hit, lin, fdo, rso;
    logic [9:0] tthr, thys;
    logic [4:0] rthr;
    logic [1:0] cg;
    logic [3:0] fg;
    logic [8:0] cm, cd, pm, pd;
    int         bad_count = 0;
    int         tests_run = 0;
    initial begin
        forever #12.5 clock_in = ~clock_in;
    end
    hstui_host host (.clock_in(clock_in), .reg_addr_out(addr),
        .reg_write_out(wr), .reg_wdata_out(wdata), .reg_read_out(rd),
        .reg_rdata_in(rdata), .reg_hit_in(hit));
    hstui_regs dut (.clock_in(clock_in), .reset_in(reset_in),
        .reg_addr_in(addr), .reg_write_in(wr), .reg_wdata_in(wdata),
        .reg_read_in(rd), .reg_rdata_out(rdata), .reg_hit_out(hit),
        .field_dir_in(fdir), .reseed_request_in(req),
        .prox_active_in(prox), .linearize_out(lin), .field_dir_out(fdo),
        .prox_threshold_out(pthr), .touch_threshold_out(tthr),
        .prox_hyst_out(phys), .touch_hyst_out(thys), .reseed_out(rso),
        .reseed_threshold_out(rthr), .coarse_gain_out(cg),
        .fine_gain_out(fg), .cal_multiplier_out(cm), .cal_divider_out(cd));
    // Packed layout shares the bus; only its calibration outputs matter
    hstui_regs #(.PACKED_CAL(1'b1)) dut_packed (.clock_in(clock_in),
        .reset_in(reset_in), .reg_addr_in(addr), .reg_write_in(wr),
        .reg_wdata_in(wdata), .reg_read_in(rd), .reg_rdata_out(),
        .reg_hit_out(), .field_dir_in(fdir), .reseed_request_in(req),
        .prox_active_in(prox), .linearize_out(), .field_dir_out(),
        .prox_threshold_out(), .touch_threshold_out(), .prox_hyst_out(),
        .touch_hyst_out(), .reseed_out(), .reseed_threshold_out(),
        .coarse_gain_out(), .fine_gain_out(), .cal_multiplier_out(pm),
        .cal_divider_out(pd));
    task automatic chk(input logic [9:0] g, input logic [9:0] e);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic settle;
        repeat (2) @(negedge clock_in);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e,
                         input logic h);
        logic [7:0] d;
        logic       ht;
        host.rd(a, d, ht);
        chk(d, e);
        chk(ht, h);
    endtask
    task automatic t_defaults;
        logic [7:0] zeros [5] = '{8'ha0, 8'hc0, 8'hc1, 8'hc2, 8'hc3};
        foreach (zeros[i]) rdchk(zeros[i], 8'h00, 1'b1);
        rdchk(8'ha1, 8'h19, 1'b1);
        rdchk(8'ha2, 8'h19, 1'b1);
        chk(pthr, 8'h19);
        chk(tthr, 10'h064);
        chk(pm, 9'h001);
        chk(pd, 9'h001);
    endtask
    task automatic t_switch;
        host.wr(8'ha1, 8'h80);
        host.wr(8'ha2, 8'hff);
        for (int m = 0; m < 4; m++) begin
            host.wr(8'ha0, {2'b11, m[1:0], 2'b11, m[1:0]});
            settle;
            chk(phys, (m == 0) ? 10'h000 : 10'h080 >> (m + 1));
            chk(thys, (m == 0) ? 10'h000 : 10'h3fc >> (m + 1));
        end
        chk(lin, 1'b1);
        chk(pthr, 8'h80);
        chk(tthr, 10'h3fc);
        rdchk(8'ha0, 8'h77, 1'b1);
        host.wr(8'ha0, 8'h00);
        settle;
        chk(lin, 1'b0);
    endtask
    task automatic t_dir;
        fdir = 1'b1;
        for (int s = 0; s < 2; s++) begin
            host.wr(8'ha0, {5'h00, s[0], 2'h0});
            settle;
            chk(fdo, !s[0]);
        end
        fdir = 1'b0;
        settle;
        chk(fdo, 1'b1);
    endtask
    task automatic t_reseed;
        // Entries: register value, proximity state, expected reseed
        logic [9:0] tbl [5] = '{10'h081, 10'h082, 10'h183, 10'h100, 10'h000};
        req = 1'b1;
        foreach (tbl[i]) begin
            host.wr(8'hc0, tbl[i][9:2]);
            prox = tbl[i][1];
            settle;
            chk(rso, tbl[i][0]);
        end
        host.wr(8'hc0, 8'hff);
        req = 1'b0;
        settle;
        chk(rso, 1'b0);
        chk(rthr, 5'h1f);
        rdchk(8'hc0, 8'h7f, 1'b1);
    endtask
    task automatic t_temp;
        host.wr(8'hc1, 8'hff);
        settle;
        chk(cg, 2'h3);
        chk(fg, 4'hf);
        host.wr(8'hc1, 8'h12);
        rdchk(8'hc1, 8'h12, 1'b1);
        chk({cg, fg}, 6'h12);
        host.wr(8'hc2, 8'hab);
        host.wr(8'hc3, 8'hcd);
        settle;
        chk(cm, 9'h0ab);
        chk(cd, 9'h0cd);
        chk(pm, 9'h00b);
        chk(pd, 9'h00c);
        rdchk(8'hc3, 8'hcd, 1'b1);
        rdchk(8'hc4, 8'h00, 1'b0);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clock_in);
        @(negedge clock_in);
        reset_in = 1'b0;
        t_defaults;
        t_switch;
        t_dir;
        t_reseed;
        t_temp;
        summarize;
    end
    initial begin
        repeat (20000) @(posedge clock_in);
        bad_count++;
        summarize;
    end
endmodule

// File: hstui_chk_sva.sv
// Port assertions for the switch and temperature UI register bank
`timescale 1ns/10ps
module hstui_chk #(
    parameter bit PACKED_CAL = 1'b0
) (
    // Clock, reset and register port
    input wire logic       clock_in,
    input wire logic       reset_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic       reg_write_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic       reg_read_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic       reg_hit_out,
    // Status inputs and decoded settings
    input wire logic       field_dir_in,
    input wire logic       reseed_request_in,
    input wire logic       prox_active_in,
    input wire logic       linearize_out,
    input wire logic       field_dir_out,
    input wire logic [7:0] prox_threshold_out,
    input wire logic [9:0] touch_threshold_out,
    input wire logic [7:0] prox_hyst_out,
    input wire logic       reseed_out
);
    // Shadows trusted only two edges after reset, so $past never sees it
    logic [7:0] sh_a0;
    logic [7:0] sh_a1;
    logic [7:0] sh_c0;
    logic [1:0] age;
    logic       mapped;
    assign mapped = reg_addr_in inside {8'ha0, 8'ha1, 8'ha2, 8'hc0, 8'hc1,
        8'hc2} || (!PACKED_CAL && reg_addr_in == 8'hc3);
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            sh_a0 <= 8'h00;
            sh_a1 <= 8'h19;
            sh_c0 <= 8'h00;
            age   <= 2'h0;
        end else begin
            if (reg_write_in && reg_addr_in == 8'ha0) sh_a0 <= reg_wdata_in;
            if (reg_write_in && reg_addr_in == 8'ha1) sh_a1 <= reg_wdata_in;
            if (reg_write_in && reg_addr_in == 8'hc0) sh_c0 <= reg_wdata_in;
            if (age != 2'h2) age <= age + 2'h1;
        end
    end
    function automatic logic [7:0] band(logic [1:0] m, logic [7:0] t);
        return (m == 2'h0) ? 8'h00 : t >> (m + 3'h1);
    endfunction
    default clocking @(posedge clock_in);
    endclocking
    default disable iff (reset_in);
    chk_prox_thr_set: assert property (
        reg_write_in && reg_addr_in == 8'ha1 |->
        ##2 prox_threshold_out == $past(reg_wdata_in, 2))
        else $error("prox threshold not taken");
    chk_touch_thr_x4: assert property (
        reg_write_in && reg_addr_in == 8'ha2 |->
        ##2 touch_threshold_out == {$past(reg_wdata_in, 2), 2'b00})
        else $error("touch threshold not four times value");
    chk_lin_follows: assert property (
        age == 2'h2 |-> linearize_out == $past(sh_a0[6]))
        else $error("linearize does not follow bit six");
    chk_dir_swap: assert property (
        age == 2'h2 |->
        field_dir_out == ($past(field_dir_in) ^ $past(sh_a0[2])))
        else $error("field direction swap wrong");
    chk_reseed_gate: assert property (
        age == 2'h2 |-> reseed_out == $past(reseed_request_in &&
        sh_c0[5] && (sh_c0[6] || !prox_active_in)))
        else $error("reseed gating wrong");
    chk_prox_band: assert property (
        age == 2'h2 |->
        prox_hyst_out == band($past(sh_a0[1:0]), $past(sh_a1)))
        else $error("prox hysteresis band wrong");
    chk_read_hit: assert property (
        reg_read_in |=> reg_hit_out == $past(mapped))
        else $error("read hit flag wrong");
    chk_unmapped_zero: assert property (
        reg_read_in && !mapped |=> reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
endmodule

bind hstui_regs hstui_chk #(.PACKED_CAL(PACKED_CAL)) chk (
    .clock_in(clock_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
    .reg_write_in(reg_write_in), .reg_wdata_in(reg_wdata_in),
    .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
    .reg_hit_out(reg_hit_out), .field_dir_in(field_dir_in),
    .reseed_request_in(reseed_request_in), .prox_active_in(prox_active_in),
    .linearize_out(linearize_out), .field_dir_out(field_dir_out),
    .prox_threshold_out(prox_threshold_out),
    .touch_threshold_out(touch_threshold_out),
    .prox_hyst_out(prox_hyst_out), .reseed_out(reseed_out));

// File: hstui_host.sv
// Host model issuing register writes and reads to the UI register bank
`timescale 1ns/10ps
module hstui_host (
    // Clock
    input  wire logic       clock_in,
    // Register access
    output logic [7:0]      reg_addr_out,
    output logic            reg_write_out,
    output logic [7:0]      reg_wdata_out,
    output logic            reg_read_out,
    input  wire logic [7:0] reg_rdata_in,
    input  wire logic       reg_hit_in
);
    initial begin
        reg_addr_out = 8'h00;
        reg_write_out = 1'b0;
        reg_wdata_out = 8'h00;
        reg_read_out = 1'b0;
    end
    // Callers keep both packed calibration nibbles below all ones
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_in);
        reg_addr_out = a;
        reg_wdata_out = d;
        reg_write_out = 1'b1;
        @(negedge clock_in);
        reg_write_out = 1'b0;
        // Released lines are inverted so a stale value cannot pass
        reg_addr_out = ~a;
        reg_wdata_out = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic h);
        @(negedge clock_in);
        reg_addr_out = a;
        reg_read_out = 1'b1;
        @(negedge clock_in);
        reg_read_out = 1'b0;
        reg_addr_out = ~a;
        d = reg_rdata_in;
        h = reg_hit_in;
    endtask
endmodule

// File: hstui_hyst.sv
// Hysteresis band from a threshold and a two-bit fraction selection
`timescale 1ns/10ps
module hstui_hyst #(
    parameter int WIDTH = 8
) (
    // Selection and threshold
    input  wire hstui_pkg::hstui_hyst_t mode_in,
    input  wire logic [WIDTH-1:0]       threshold_in,
    // Resulting band
    output logic [WIDTH-1:0]            band_out
);
    import hstui_pkg::*;

    always_comb begin
        unique case (mode_in)
            HSTUI_HYST_OFF:       band_out = '0;
            HSTUI_HYST_QUARTER:   band_out = threshold_in >> 2;
            HSTUI_HYST_EIGHTH:    band_out = threshold_in >> 3;
            HSTUI_HYST_SIXTEENTH: band_out = threshold_in >> 4;
        endcase
    end

endmodule

// File: hstui_pkg.sv
// Register map, field layout and reset values of the switch and temperature UI
package hstui_pkg;

    // Register offsets
    localparam logic [7:0] SWITCH_CFG_ADDR   = 8'ha0;
    localparam logic [7:0] PROX_THR_ADDR     = 8'ha1;
    localparam logic [7:0] TOUCH_THR_ADDR    = 8'ha2;
    localparam logic [7:0] RESEED_CFG_ADDR   = 8'hc0;
    localparam logic [7:0] TEMP_GAIN_ADDR    = 8'hc1;
    localparam logic [7:0] CAL_PACKED_ADDR   = 8'hc2;
    localparam logic [7:0] CAL_MULT_ADDR     = 8'hc2;
    localparam logic [7:0] CAL_DIV_ADDR      = 8'hc3;

    // Reset values
    localparam logic [7:0] SWITCH_CFG_RESET  = 8'h00;
    localparam logic [7:0] PROX_THR_RESET    = 8'h19;
    localparam logic [7:0] TOUCH_THR_RESET   = 8'h19;
    localparam logic [7:0] RESEED_CFG_RESET  = 8'h00;
    localparam logic [7:0] TEMP_GAIN_RESET   = 8'h00;
    localparam logic [7:0] CAL_RESET         = 8'h00;

    // Writable bits per register; the rest read as zero
    localparam logic [7:0] SWITCH_CFG_MASK   = 8'h77;
    localparam logic [7:0] RESEED_CFG_MASK   = 8'h7f;
    localparam logic [7:0] TEMP_GAIN_MASK    = 8'h3f;

    // Switch configuration fields
    localparam int LIN_BIT        = 6;
    localparam int TOUCH_HYST_LSB = 4;
    localparam int SWAP_BIT       = 2;
    localparam int PROX_HYST_LSB  = 0;

    // Temperature reseed configuration fields
    localparam int RESEED_PROX_BIT = 6;
    localparam int RESEED_EN_BIT   = 5;
    localparam int RESEED_THR_LSB  = 0;
    localparam int RESEED_THR_W    = 5;

    // Gain select fields
    localparam int COARSE_LSB = 4;
    localparam int COARSE_W   = 2;
    localparam int FINE_LSB   = 0;
    localparam int FINE_W     = 4;

    // Packed calibration fields
    localparam int CAL_MULT_LSB = 4;
    localparam int CAL_DIV_LSB  = 0;
    localparam int CAL_NIB_W    = 4;

    // Touch threshold scale is a shift by two, a factor of four
    localparam int TOUCH_SCALE_SHIFT = 2;

    // Hysteresis selection codes
    typedef enum logic [1:0] {
        HSTUI_HYST_OFF       = 2'b00,
        HSTUI_HYST_QUARTER   = 2'b01,
        HSTUI_HYST_EIGHTH    = 2'b10,
        HSTUI_HYST_SIXTEENTH = 2'b11
    } hstui_hyst_t;

endpackage

// File: hstui_regs.sv
// Switch and temperature UI configuration registers with decoded outputs
`timescale 1ns/10ps

// Function
// - Touch hysteresis code: off, 1/4, 1/8, 1/16
// - Prox hysteresis code uses the same fractions
// - Bit six enables switch output linearization
// - Bit two swaps reported field direction
// - Prox threshold used directly, resets 0x19
// - Touch threshold is register value times four, but zero during reset
// - Reseed in prox only if bit six set
// - Reseeding happens only with enable bit set
// - Reseed threshold is five-bit field, unscaled
// - Temperature channel coarse 2-bit, fine 4-bit gains
// - Packed multiplier is upper nibble plus one
// - Packed divider is lower nibble plus one
// - Newer variant: full-byte multiplier, divider registers
module hstui_regs #(
    parameter bit PACKED_CAL = 1'b0
) (
    // Clock and reset
    input  wire logic        clock_in,
    input  wire logic        reset_in,
    // Register access from the serial interface engine
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic        reg_write_in,
    input  wire logic [7:0]  reg_wdata_in,
    input  wire logic        reg_read_in,
    output logic [7:0]       reg_rdata_out,
    output logic             reg_hit_out,
    // Magnetic switch status from the measurement engine
    input  wire logic        field_dir_in,
    // Temperature reseed request and proximity state
    input  wire logic        reseed_request_in,
    input  wire logic        prox_active_in,
    // Switch settings
    output logic             linearize_out,
    output logic             field_dir_out,
    output logic [7:0]       prox_threshold_out,
    output logic [9:0]       touch_threshold_out,
    output logic [7:0]       prox_hyst_out,
    output logic [9:0]       touch_hyst_out,
    // Temperature settings
    output logic             reseed_out,
    output logic [hstui_pkg::RESEED_THR_W-1:0] reseed_threshold_out,
    output logic [hstui_pkg::COARSE_W-1:0]     coarse_gain_out,
    output logic [hstui_pkg::FINE_W-1:0]       fine_gain_out,
    output logic [8:0]       cal_multiplier_out,
    output logic [8:0]       cal_divider_out
);
    import hstui_pkg::*;

    logic [7:0]  switch_cfg;
    logic [7:0]  prox_thr;
    logic [7:0]  touch_thr;
    logic [7:0]  reseed_cfg;
    logic [7:0]  temp_gain;
    logic [7:0]  cal_mult;
    logic [7:0]  cal_div;
    logic [7:0]  next_rdata;
    logic        next_hit;
    logic [9:0]  touch_scaled;
    logic [7:0]  prox_band;
    logic [9:0]  touch_band;

    // Address decode; in the packed layout 0xc3 is not ours
    always_comb begin
        next_rdata = 8'h00;
        next_hit   = 1'b1;
        unique case (reg_addr_in)
            SWITCH_CFG_ADDR: next_rdata = switch_cfg & SWITCH_CFG_MASK;
            PROX_THR_ADDR:   next_rdata = prox_thr;
            TOUCH_THR_ADDR:  next_rdata = touch_thr;
            RESEED_CFG_ADDR: next_rdata = reseed_cfg & RESEED_CFG_MASK;
            TEMP_GAIN_ADDR:  next_rdata = temp_gain & TEMP_GAIN_MASK;
            CAL_MULT_ADDR: begin
                if (PACKED_CAL) begin
                    next_rdata = {cal_mult[CAL_NIB_W-1:0],
                                  cal_div[CAL_NIB_W-1:0]};
                end else begin
                    next_rdata = cal_mult;
                end
            end
            CAL_DIV_ADDR: begin
                if (PACKED_CAL) begin
                    next_hit = 1'b0;
                end else begin
                    next_rdata = cal_div;
                end
            end
            default: next_hit = 1'b0;
        endcase
    end

    // Read answer; an unmapped address answers zero
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            reg_rdata_out <= 8'h00;
            reg_hit_out   <= 1'b0;
        end else if (reg_read_in) begin
            reg_rdata_out <= next_rdata;
            reg_hit_out   <= next_hit;
        end
    end

    // Switch registers
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            switch_cfg <= SWITCH_CFG_RESET;
            prox_thr   <= PROX_THR_RESET;
            touch_thr  <= TOUCH_THR_RESET;
        end else if (reg_write_in) begin
            if (reg_addr_in == SWITCH_CFG_ADDR) begin
                switch_cfg <= reg_wdata_in & SWITCH_CFG_MASK;
            end
            if (reg_addr_in == PROX_THR_ADDR) begin
                prox_thr <= reg_wdata_in;
            end
            if (reg_addr_in == TOUCH_THR_ADDR) begin
                touch_thr <= reg_wdata_in;
            end
        end
    end

    // Temperature registers
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            reseed_cfg <= RESEED_CFG_RESET;
            temp_gain  <= TEMP_GAIN_RESET;
        end else if (reg_write_in) begin
            if (reg_addr_in == RESEED_CFG_ADDR) begin
                reseed_cfg <= reg_wdata_in & RESEED_CFG_MASK;
            end
            if (reg_addr_in == TEMP_GAIN_ADDR) begin
                temp_gain <= reg_wdata_in & TEMP_GAIN_MASK;
            end
        end
    end

    // Calibration storage; packed layout keeps only the low nibbles
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            cal_mult <= CAL_RESET;
            cal_div  <= CAL_RESET;
        end else if (reg_write_in) begin
            if (PACKED_CAL) begin
                if (reg_addr_in == CAL_PACKED_ADDR) begin
                    cal_mult <= {4'h0, reg_wdata_in[CAL_MULT_LSB +: CAL_NIB_W]};
                    cal_div  <= {4'h0, reg_wdata_in[CAL_DIV_LSB +: CAL_NIB_W]};
                end
            end else begin
                if (reg_addr_in == CAL_MULT_ADDR) begin
                    cal_mult <= reg_wdata_in;
                end
                if (reg_addr_in == CAL_DIV_ADDR) begin
                    cal_div <= reg_wdata_in;
                end
            end
        end
    end

    assign touch_scaled = {touch_thr, 2'b00};

    // Hysteresis bands from the unscaled prox threshold and the scaled touch threshold
    hstui_hyst #(
        .WIDTH        (8)
    ) u_prox_hyst (
        .mode_in      (hstui_hyst_t'(switch_cfg[PROX_HYST_LSB +: 2])),
        .threshold_in (prox_thr),
        .band_out     (prox_band)
    );

    hstui_hyst #(
        .WIDTH        (10)
    ) u_touch_hyst (
        .mode_in      (hstui_hyst_t'(switch_cfg[TOUCH_HYST_LSB +: 2])),
        .threshold_in (touch_scaled),
        .band_out     (touch_band)
    );

    // Switch outputs, registered so they change one edge after the write
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            linearize_out       <= 1'b0;
            field_dir_out       <= 1'b0;
            prox_threshold_out  <= PROX_THR_RESET;
            touch_threshold_out <= 10'h000;
            prox_hyst_out       <= 8'h00;
            touch_hyst_out      <= 10'h000;
        end else begin
            linearize_out       <= switch_cfg[LIN_BIT];
            field_dir_out       <= field_dir_in ^ switch_cfg[SWAP_BIT];
            prox_threshold_out  <= prox_thr;
            touch_threshold_out <= touch_scaled;
            prox_hyst_out       <= prox_band;
            touch_hyst_out      <= touch_band;
        end
    end

    // Reseed gate: request is held off during prox unless allowed
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            reseed_out           <= 1'b0;
            reseed_threshold_out <= '0;
        end else begin
            reseed_out <= reseed_request_in
                        & reseed_cfg[RESEED_EN_BIT]
                        & (reseed_cfg[RESEED_PROX_BIT]
                           | ~prox_active_in);
            reseed_threshold_out <=
                reseed_cfg[RESEED_THR_LSB +: RESEED_THR_W];
        end
    end

    // Temperature gain and calibration outputs
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            coarse_gain_out    <= '0;
            fine_gain_out      <= '0;
            cal_multiplier_out <= 9'h001;
            cal_divider_out    <= 9'h001;
        end else begin
            coarse_gain_out <= temp_gain[COARSE_LSB +: COARSE_W];
            fine_gain_out   <= temp_gain[FINE_LSB +: FINE_W];
            if (PACKED_CAL) begin
                // All-ones nibble would overflow downstream; host avoids it
                cal_multiplier_out <= {1'b0, cal_mult} + 9'h001;
                cal_divider_out    <= {1'b0, cal_div} + 9'h001;
            end else begin
                cal_multiplier_out <= {1'b0, cal_mult};
                cal_divider_out    <= {1'b0, cal_div};
            end
        end
    end

endmodule
